// [rfi_defs.vh]
// Notes on behaviour
// - Four reset sources: soft bit, ext_reset_n pin, supply lockout, selected watchdog expiry.
// - Writing 1 to soft_reset_bit resets; the bit self-clears and reads zero.
// - Soft reset disables converters, outputs low, registers default, then loads OTP defaults.
// - Host interface logic keeps its state through a soft reset.
// - Lockout or ext_reset_n low: converters off, outputs low, registers default.
// - After supply and pin release, OTP defaults load and start-up begins.
// - A selected watchdog expiry returns registers to OTP defaults.
// - Per-monitor enables; shared window bit: 0 undervoltage only, 1 both.
// - Buck window field picks +-30/50/70/90 mV around its nominal setting.
// - Boost nominal picks 4.9/5/5.1/5.2 V; window +-2/4/6/8 percent.
// - Supply nominal bit picks 3.3 or 5 V; window bit 5 or 10 percent.
// - External monitor threshold 0.65 to 1.8 V; window +-2/3/4/6 percent.
// - Events set flags and pull irq_out_n low until all unmasked pending cleared.
// - Every start-up sets the register-reset flag.
// - Buck limit 20 us or boost limit sets maskable flag, live status, sticky.
// - Output below 0.35 V 1 ms after enable or 1 ms running flags, disables.
// - Thermal warning: maskable flag, live status, no clear while hot.
// - Thermal shutdown disables converters, outputs low, unmaskable flag held while hot.
// - Negative current limit raises no flag and disables nothing.
`ifndef RFI_DEFS_VH
`define RFI_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RFI_ADDR_RESET_CTRL 8'h00
`define RFI_ADDR_MON_CTRL   8'h04
`define RFI_ADDR_BUCK_NOM_A 8'h08
`define RFI_ADDR_BUCK_NOM_B 8'h0c
`define RFI_ADDR_MON_LEVEL  8'h10
`define RFI_ADDR_INT_FLAGS  8'h14
`define RFI_ADDR_INT_MASK   8'h18
`define RFI_ADDR_STATUS     8'h1c
`define RFI_ADDR_CONV_CTRL  8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define RFI_SOFT_RESET_BIT 0
`define RFI_WD_RELOAD_BIT  1
`define RFI_WINDOW_BIT     8
`define RFI_GPO_LSB        4
`define RFI_FLAG_REGRESET  8
`define RFI_FLAG_TSD       7
`define RFI_FLAG_WARN      6
`define RFI_MASKABLE       9'h147

// ****************************************************************
// One-time-programmable defaults
// ****************************************************************
`define RFI_OTP_CONV      3'h0
`define RFI_OTP_GPO       2'h0
`define RFI_OTP_WD_RELOAD 1'h1
`define RFI_OTP_MON_EN    6'h00
`define RFI_OTP_WINDOW    1'h0
`define RFI_OTP_BUCK_NOM  8'h00
`define RFI_OTP_LEVEL     22'h000000
`define RFI_OTP_MASK      9'h000

// ****************************************************************
// Timing
// ****************************************************************
`define RFI_CLK_MHZ      100
`define RFI_ILIM_DEB_US  20
`define RFI_SC_DEB_US    1000
`define RFI_HOST_WAIT_US 1200
`define RFI_ILIM_DEB_CYC (`RFI_ILIM_DEB_US * `RFI_CLK_MHZ)
`define RFI_SC_DEB_CYC   (`RFI_SC_DEB_US * `RFI_CLK_MHZ)
`define RFI_HOST_WAIT_CYC (`RFI_HOST_WAIT_US * `RFI_CLK_MHZ)

`endif

// [rfi_reset_fault.v]
`include "rfi_defs.vh"
`default_nettype none

module rfi_reset_fault #(
    parameter SC_CYC = `RFI_SC_DEB_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ext_reset_n,
    input  wire        supply_uvlo,
    input  wire        wd_expire,
    input  wire [1:0]  buck_ilim,
    input  wire        boost_ilim,
    input  wire [2:0]  conv_out_low,
    input  wire        thermal_warn,
    input  wire        thermal_sd,
    output reg  [2:0]  conv_enable,
    output reg  [1:0]  general_output,
    output reg  [5:0]  monitor_enable_reg,
    output reg         monitor_window_mode,
    output reg  [7:0]  buck_nominal_setting_a,
    output reg  [7:0]  buck_nominal_setting_b,
    output reg  [21:0] monitor_levels,
    output reg         irq_out_n
);

    // ****************************************************************
    // Reset sequencing
    // ****************************************************************
    localparam [1:0] ST_RST  = 2'h0;
    localparam [1:0] ST_LOAD = 2'h1;
    localparam [1:0] ST_RUN  = 2'h2;
    localparam integer SC_LAST_I   = SC_CYC - 1;
    localparam integer ILIM_LAST_I = `RFI_ILIM_DEB_CYC - 1;
    localparam [16:0] SC_LAST   = SC_LAST_I[16:0];
    localparam [10:0] ILIM_LAST = ILIM_LAST_I[10:0];

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg         soft_q;
    reg         wd_reload_q;
    reg  [2:0]  conv_q;
    reg  [1:0]  gpo_q;
    reg  [8:0]  flag_q;
    reg  [8:0]  flag_d;
    reg  [8:0]  mask_q;
    wire [2:0]  ilim_live_q;
    wire [2:0]  short_hit;
    reg  [31:0] rdata;
    reg         rmapped;
    wire        acc;
    wire        wr;
    wire        reset_cause;
    wire        run;

    // Writes land only at the edge where the master sees pready high.
    assign acc = psel & penable & pready;
    assign wr  = acc & pwrite & (state_q == ST_RUN);
    assign run = (state_q == ST_RUN);

    // Soft reset and pin/lockout sources clear the core; the APB slave keeps going.
    assign reset_cause = soft_q | ~ext_reset_n | supply_uvlo
                       | (wd_expire & wd_reload_q);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RST:  if (!reset_cause) state_d = ST_LOAD;
            ST_LOAD: state_d = ST_RUN;
            ST_RUN:  if (reset_cause) state_d = ST_RST;
            default: state_d = ST_RST;
        endcase
        if (reset_cause) state_d = ST_RST;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RST;
            soft_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            // One-cycle pulse; the stored bit never reads back as set.
            soft_q  <= wr && paddr == `RFI_ADDR_RESET_CTRL
                       && pwdata[`RFI_SOFT_RESET_BIT];
        end
    end

    // ****************************************************************
    // Current limit debounce and short-circuit timers
    // ****************************************************************
    wire [2:0] ilim_raw;
    assign ilim_raw = {boost_ilim, buck_ilim};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_conv
            reg [10:0] deb_q;
            reg [16:0] sc_q;
            reg        started_q;
            reg        live_q;

            assign ilim_live_q[gi] = live_q;

            // Buck limits must persist 20 us; the boost limit counts at once.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    deb_q  <= 11'h000;
                    live_q <= 1'b0;
                end else if (!ilim_raw[gi] || !run) begin
                    deb_q  <= 11'h000;
                    live_q <= 1'b0;
                end else if (gi == 2 || deb_q == ILIM_LAST) begin
                    live_q <= 1'b1;
                end else begin
                    deb_q <= deb_q + 11'h001;
                end
            end

            // During soft-start the timer always runs; afterwards only while low.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sc_q      <= 17'h00000;
                    started_q <= 1'b0;
                end else if (!conv_enable[gi]) begin
                    sc_q      <= 17'h00000;
                    started_q <= 1'b0;
                end else if (sc_q == SC_LAST) begin
                    sc_q      <= 17'h00000;
                    started_q <= 1'b1;
                end else if (conv_out_low[gi] || !started_q) begin
                    sc_q <= sc_q + 17'h00001;
                end else begin
                    sc_q <= 17'h00000;
                end
            end

            assign short_hit[gi] = conv_enable[gi] && sc_q == SC_LAST
                                   && conv_out_low[gi];
        end
    endgenerate

    // ****************************************************************
    // Interrupt flags
    // ****************************************************************
    // Negative current limit has no input here: it never flags or disables.
    reg [8:0] flag_set;
    reg [8:0] flag_clr;

    always @* begin
        flag_set = {1'b0, thermal_sd, thermal_warn, short_hit, ilim_live_q};
        flag_clr = 9'h000;
        if (wr && paddr == `RFI_ADDR_INT_FLAGS) flag_clr = pwdata[8:0];
        // A live condition re-sets its flag in the clearing cycle.
        flag_d = (flag_q & ~flag_clr) | flag_set;
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_reload_q            <= 1'b0;
            conv_q                 <= 3'h0;
            gpo_q                  <= 2'h0;
            monitor_enable_reg     <= 6'h00;
            monitor_window_mode    <= 1'b0;
            buck_nominal_setting_a <= 8'h00;
            buck_nominal_setting_b <= 8'h00;
            monitor_levels         <= 22'h000000;
            mask_q                 <= 9'h000;
            flag_q                 <= 9'h000;
        end else if (state_q == ST_RST) begin
            // Every register is held at its default while a reset source is active.
            wd_reload_q            <= 1'b0;
            conv_q                 <= 3'h0;
            gpo_q                  <= 2'h0;
            monitor_enable_reg     <= 6'h00;
            monitor_window_mode    <= 1'b0;
            buck_nominal_setting_a <= 8'h00;
            buck_nominal_setting_b <= 8'h00;
            monitor_levels         <= 22'h000000;
            mask_q                 <= 9'h000;
            flag_q                 <= 9'h000;
        end else if (state_q == ST_LOAD) begin
            wd_reload_q            <= `RFI_OTP_WD_RELOAD;
            conv_q                 <= `RFI_OTP_CONV;
            gpo_q                  <= `RFI_OTP_GPO;
            monitor_enable_reg     <= `RFI_OTP_MON_EN;
            monitor_window_mode    <= `RFI_OTP_WINDOW;
            buck_nominal_setting_a <= `RFI_OTP_BUCK_NOM;
            buck_nominal_setting_b <= `RFI_OTP_BUCK_NOM;
            monitor_levels         <= `RFI_OTP_LEVEL;
            mask_q                 <= `RFI_OTP_MASK;
            flag_q                 <= 9'h100;
        end else begin
            flag_q <= flag_d;
            if (wr) begin
                case (paddr)
                    `RFI_ADDR_RESET_CTRL: wd_reload_q <= pwdata[`RFI_WD_RELOAD_BIT];
                    `RFI_ADDR_MON_CTRL: begin
                        monitor_enable_reg  <= pwdata[5:0];
                        monitor_window_mode <= pwdata[`RFI_WINDOW_BIT];
                    end
                    `RFI_ADDR_BUCK_NOM_A: buck_nominal_setting_a <= pwdata[7:0];
                    `RFI_ADDR_BUCK_NOM_B: buck_nominal_setting_b <= pwdata[7:0];
                    // Buck, boost, supply and external windows and nominals.
                    `RFI_ADDR_MON_LEVEL: monitor_levels <= pwdata[21:0];
                    `RFI_ADDR_INT_MASK: mask_q <= pwdata[8:0] & `RFI_MASKABLE;
                    `RFI_ADDR_CONV_CTRL: begin
                        conv_q <= pwdata[2:0];
                        gpo_q  <= pwdata[`RFI_GPO_LSB+1:`RFI_GPO_LSB];
                    end
                    default: ;
                endcase
            end
            // A short circuit turns its converter off and wins over a same-cycle write.
            conv_q <= (wr && paddr == `RFI_ADDR_CONV_CTRL ? pwdata[2:0] : conv_q)
                      & ~short_hit;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_enable    <= 3'h0;
            general_output <= 2'h0;
            irq_out_n      <= 1'b1;
        end else begin
            // Thermal shutdown and any reset force converters off and outputs low.
            conv_enable    <= (run && !thermal_sd) ? conv_q & ~short_hit : 3'h0;
            general_output <= (run && !thermal_sd) ? gpo_q : 2'h0;
            irq_out_n      <= ~|(flag_q & ~mask_q);
        end
    end

    // ****************************************************************
    // APB read path
    // ****************************************************************
    always @* begin
        rdata   = 32'h00000000;
        rmapped = 1'b1;
        case (paddr)
            `RFI_ADDR_RESET_CTRL: rdata = {30'h0, wd_reload_q, 1'b0};
            `RFI_ADDR_MON_CTRL:   rdata = {23'h0, monitor_window_mode, 2'h0,
                                           monitor_enable_reg};
            `RFI_ADDR_BUCK_NOM_A: rdata = {24'h0, buck_nominal_setting_a};
            `RFI_ADDR_BUCK_NOM_B: rdata = {24'h0, buck_nominal_setting_b};
            `RFI_ADDR_MON_LEVEL:  rdata = {10'h0, monitor_levels};
            // Group bits 9 (bucks) and 10 (boost) summarise the converter flags.
            `RFI_ADDR_INT_FLAGS:  rdata = {21'h0, flag_q[2] | flag_q[5],
                                           |{flag_q[0], flag_q[1], flag_q[3], flag_q[4]},
                                           flag_q};
            `RFI_ADDR_INT_MASK:   rdata = {23'h0, mask_q};
            `RFI_ADDR_STATUS:     rdata = {27'h0, thermal_sd, thermal_warn,
                                           ilim_live_q};
            `RFI_ADDR_CONV_CTRL:  rdata = {26'h0, gpo_q, 1'b0, conv_q};
            default:              rmapped = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : rdata;
            pslverr <= ~rmapped;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

endmodule // rfi_reset_fault

`default_nettype wire

// [rfi_plant.sv]
`default_nettype none
module rfi_plant (
    input  wire logic [2:0] conv_enable,
    input  wire logic [2:0] short_cmd,
    output logic      [2:0] conv_out_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // A converter that is off has no output, so its comparator also reads low.
    assign conv_out_low = short_cmd | ~conv_enable;
endmodule // rfi_plant
`default_nettype wire

// [rfi_chk_sva.sv]
`default_nettype none
module rfi_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_reset_n,
    input wire logic        supply_uvlo,
    input wire logic        thermal_sd,
    input wire logic [2:0]  conv_enable,
    input wire logic [1:0]  general_output,
    input wire logic        irq_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_off;
        conv_enable == 3'h0 && general_output == 2'h0;
    endsequence
    property p_wait;
        psel && penable && !pready |=> pready;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_unmap;
        pready && psel && paddr > 8'h20 |-> pslverr && prdata == 32'h0;
    endproperty
    property p_swr;
        pready && !pwrite && paddr == 8'h00 |-> !prdata[0];
    endproperty
    property p_core;
        supply_uvlo || !ext_reset_n |-> ##2 s_off;
    endproperty
    property p_tsd;
        thermal_sd |-> ##[0:2] s_off;
    endproperty
    property p_tsd_irq;
        thermal_sd [*3] |-> !irq_out_n;
    endproperty
    property p_start;
        $rose(presetn) |-> ##[1:3] !irq_out_n;
    endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait state");
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    a_swr: assert property (p_swr) else $error("soft reset bit reads set");
    a_core: assert property (p_core) else $error("outputs on in core reset");
    a_tsd: assert property (p_tsd) else $error("outputs on in shutdown");
    a_tsd_irq: assert property (p_tsd_irq) else $error("shutdown irq missing");
    a_start: assert property (p_start) else $error("no reset flag irq");
endmodule // rfi_chk
bind rfi_reset_fault rfi_chk i_rfi_chk (.*);
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    // The full host wait would dwarf the run; the core needs only its load cycle.
    localparam int HW = 50;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, buck_nominal_setting_a, buck_nominal_setting_b;
    logic [31:0] pwdata, prdata, rd;
    logic        ext_reset_n, supply_uvlo, wd_expire, boost_ilim, irq_out_n;
    logic        thermal_warn, thermal_sd, monitor_window_mode;
    logic [1:0]  buck_ilim, general_output;
    logic [2:0]  conv_out_low, conv_enable, short_cmd;
    logic [5:0]  monitor_enable_reg;
    logic [21:0] monitor_levels;
    int          err_total = 0;
    int          n_checks = 0;
    rfi_reset_fault #(.SC_CYC(SC)) i_rfi_reset_fault (.*);
    rfi_plant i_rfi_plant (.*);
    always #5 pclk = ~pclk;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic stop_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t no bus answer", $time);
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {supply_uvlo, wd_expire, boost_ilim, thermal_warn, thermal_sd} = '0;
        {buck_ilim, short_cmd} = '0;
        ext_reset_n = 1'b1;
        cyc(5);
        presetn <= 1'b1;
        cyc(HW);
        rdc(8'h00, 32'hffffffff, 32'h2);
        rdc(8'h14, 32'hffffffff, 32'h100);
        chk(32'(irq_out_n), 32'h0);
        wr(8'h14, 32'h100);
        cyc(3);
        chk(32'(irq_out_n), 32'h1);
        wr(8'h04, 32'h13f);
        wr(8'h10, 32'h3fc3ff);
        wr(8'h08, 32'ha5);
        wr(8'h0c, 32'h5a);
        rdc(8'h04, 32'hffffffff, 32'h13f);
        chk(32'({monitor_window_mode, monitor_enable_reg}), 32'h7f);
        chk(32'(monitor_levels), 32'h3fc3ff);
        chk(32'({buck_nominal_setting_b, buck_nominal_setting_a}), 32'h5aa5);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        wr(8'h20, 32'h37);
        cyc(3);
        chk(32'({general_output, conv_enable}), 32'h1f);
        boost_ilim <= 1'b1;
        @(posedge pclk) boost_ilim <= 1'b0;
        cyc(3);
        rdc(8'h14, 32'hffffffff, 32'h404);
        chk(32'(irq_out_n), 32'h0);
        wr(8'h14, 32'h4);
        wr(8'h18, 32'h4);
        boost_ilim <= 1'b1;
        @(posedge pclk) boost_ilim <= 1'b0;
        cyc(3);
        chk(32'(irq_out_n), 32'h1);
        wr(8'h14, 32'h4);
        buck_ilim <= 2'h1;
        cyc(1990);
        rdc(8'h14, 32'h1ff, 32'h0);
        cyc(20);
        rdc(8'h14, 32'hffffffff, 32'h201);
        rdc(8'h1c, 32'h1f, 32'h1);
        buck_ilim <= 2'h0;
        thermal_warn <= 1'b1;
        cyc(3);
        wr(8'h14, 32'h41);
        rdc(8'h14, 32'h1ff, 32'h40);
        rdc(8'h1c, 32'h1f, 32'h8);
        thermal_warn <= 1'b0;
        wr(8'h14, 32'h40);
        short_cmd <= 3'h1;
        cyc(SC + 5);
        chk(32'(conv_enable), 32'h6);
        rdc(8'h14, 32'h1ff, 32'h8);
        short_cmd <= 3'h0;
        wr(8'h14, 32'h8);
        wr(8'h20, 32'h37);
        thermal_sd <= 1'b1;
        cyc(4);
        chk(32'({general_output, conv_enable}), 32'h0);
        wr(8'h14, 32'h80);
        rdc(8'h14, 32'h1ff, 32'h80);
        rdc(8'h1c, 32'h1f, 32'h10);
        thermal_sd <= 1'b0;
        wr(8'h14, 32'h80);
        wr(8'h20, 32'h37);
        wr(8'h00, 32'h1);
        cyc(HW);
        chk(32'({general_output, conv_enable}), 32'h0);
        rdc(8'h00, 32'hffffffff, 32'h2);
        rdc(8'h14, 32'hffffffff, 32'h100);
        // With reload deselected a watchdog expiry must leave the core running.
        wr(8'h00, 32'h0);
        wr(8'h20, 32'h37);
        wd_expire <= 1'b1;
        cyc(4);
        wd_expire <= 1'b0;
        chk(32'({general_output, conv_enable}), 32'h1f);
        rdc(8'h00, 32'hffffffff, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(8'h20, 32'h37);
            wr(8'h14, 32'h100);
            cyc(2);
            ext_reset_n <= (k != 0);
            supply_uvlo <= (k == 1);
            wd_expire <= (k == 2);
            cyc(4);
            chk(32'({general_output, conv_enable}), 32'h0);
            {ext_reset_n, supply_uvlo, wd_expire} <= 3'b100;
            cyc(HW);
            rdc(8'h20, 32'hffffffff, 32'h0);
            rdc(8'h14, 32'hffffffff, 32'h100);
        end
        stop_test();
    end
endmodule // testbench
`default_nettype wire
